//--- core/tw_pkg.sv
/*
  Shared constants for the two-wire EEPROM device end and the bus
  master end: timing counts, address layout, slave address types,
  pin sampling layout and the master's own register map.
  Assumes a 50 MHz system clock on both ends.
*/
package tw_pkg;

  // System clock and derived timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TWR_NS        = 10_000_000;
  localparam int unsigned TWR_CYCLES    = TWR_NS / CLK_PERIOD_NS;
  localparam int unsigned SCL_PERIOD_NS = 10_000;
  localparam int unsigned QTR_CYCLES    = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int unsigned QTR_W         = $clog2(QTR_CYCLES);

  // Array layout
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MEM_DEPTH  = 256;
  localparam int unsigned PAGE_W     = 4;
  localparam int unsigned PAGE_BYTES = 16;

  // Bit counters
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] FRAME_LAST = 4'h8;

  // Slave address type nibbles
  localparam logic [3:0] TYPE_MEM  = 4'hA;
  localparam logic [3:0] TYPE_PROT = 4'h6;

  // Device pin sampling vector layout and idle levels
  localparam int unsigned SY_SCL = 0;
  localparam int unsigned SY_SDA = 1;
  localparam int unsigned SY_WI  = 2;
  localparam int unsigned SY_S0  = 3;
  localparam int unsigned SY_S2  = 5;
  localparam int unsigned SY_W   = 6;
  localparam logic [SY_W-1:0] SY_RST = 6'h03;

  // Master register map (word index on the plain port)
  localparam int unsigned REG_AW   = 3;
  localparam logic [REG_AW-1:0] REG_CMD  = 3'h0;
  localparam logic [REG_AW-1:0] REG_TXD  = 3'h1;
  localparam logic [REG_AW-1:0] REG_RXD  = 3'h2;
  localparam logic [REG_AW-1:0] REG_STAT = 3'h3;
  localparam logic [REG_AW-1:0] REG_CTRL = 3'h4;

  // Command bits
  localparam int unsigned CMD_START = 0;
  localparam int unsigned CMD_STOP  = 1;
  localparam int unsigned CMD_WRITE = 2;
  localparam int unsigned CMD_READ  = 3;
  localparam int unsigned CMD_NACK  = 4;

  // Status and control bits
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_ACK   = 1;
  localparam int unsigned STAT_FRAME = 2;
  localparam int unsigned CTRL_WI    = 0;

endpackage

//--- core/tw_if.sv
/*
  Two-wire bus between the master end and the EEPROM device end.
  Holds the wired-AND data line with its pull-up and the write
  inhibit pin with its pull-down; no clock lives here.
*/
`timescale 1ns/1ps
interface tw_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic wi_o;
  logic wi_oe;
  logic sda;
  logic write_inhibit_pin;

  // Open drain with pull-up: any enabled low driver wins
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
               (dev_sda_oe ? dev_sda_o : 1'b1);
  // Pin floats low when nobody drives it
  assign write_inhibit_pin = wi_oe ? wi_o : 1'b0;

  modport dev (
    input  scl,
    input  sda,
    input  write_inhibit_pin,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    output wi_o,
    output wi_oe,
    input  sda
  );
endinterface

//--- core/tw_eeprom_dev.sv
/*
  Device end: 256 x 8 two-wire EEPROM slave with page write, one-time
  protect of the lower half, write inhibit pin and a busy period.
  Assumes bus pins arrive unsynchronised and are sampled here.
*/
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module tw_eeprom_dev #(
  parameter int unsigned BUSY_CYCLES = tw_pkg::TWR_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  input  wire logic select_bit0_i,
  input  wire logic select_bit1_i,
  input  wire logic select_bit2_i,
  output logic      busy_o,
  output logic      protect_o,
  tw_if.dev         bus
);
  import tw_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK, D_WAIT, D_BUSY
  } tw_dev_state_t;
  typedef enum logic [1:0] {K_ADDR, K_WORD, K_DATA} tw_kind_t;

  localparam int unsigned CW = $clog2(BUSY_CYCLES + 1);
  localparam logic [CW-1:0] BUSY_LOAD = CW'(BUSY_CYCLES - 1);

  tw_dev_state_t         st_q;
  tw_kind_t              kind_q;
  logic [SY_W-1:0]       sy1_q;
  logic [SY_W-1:0]       sy2_q;
  logic [SY_W-1:0]       sy3_q;
  logic [SY_W-1:0]       pin_q;
  logic [SY_W-1:0]       pin_last_q;
  logic [3:0]            bit_q;
  logic [DATA_W-1:0]     shift_q;
  logic [ADDR_W-1:0]     ptr_q;
  logic [PAGE_BYTES-1:0] pvld_q;
  logic [CW-1:0]         cnt_q;
  logic                  rd_q;
  logic                  prot_cmd_q;
  logic                  prot_pend_q;
  logic                  sda_oe_q;
  logic                  busy_q;
  // Nonvolatile: survives reset, only ever set
  logic                  prot_q = 1'b0;
  logic [DATA_W-1:0]     mem_q  [MEM_DEPTH];
  logic [DATA_W-1:0]     page_q [PAGE_BYTES];

  // Pins pass three flops; a level counts once stages two and three agree
  wire [SY_W-1:0] pin_raw = {select_bit2_i, select_bit1_i, select_bit0_i,
                             bus.write_inhibit_pin, bus.sda, bus.scl};
  wire [SY_W-1:0] pin_d   = (sy2_q & sy3_q) | (pin_q & (sy2_q ^ sy3_q));

  wire scl_f    = pin_q[SY_SCL];
  wire sda_f    = pin_q[SY_SDA];
  wire wi_f     = pin_q[SY_WI];
  wire scl_rise = scl_f & ~pin_last_q[SY_SCL];
  wire scl_fall = ~scl_f & pin_last_q[SY_SCL];
  wire start_ev = scl_f & pin_last_q[SY_SCL] & pin_last_q[SY_SDA] & ~sda_f;
  wire stop_ev  = scl_f & pin_last_q[SY_SCL] & ~pin_last_q[SY_SDA] & sda_f;

  // Slave address decode on the received byte
  wire [3:0] hdr      = shift_q[DATA_W-1:DATA_W-4];
  wire       sel_hit  = shift_q[3:1] == pin_q[SY_S2:SY_S0];
  wire       is_prot  = (hdr == TYPE_PROT) & ~shift_q[0];
  wire       addr_hit = sel_hit & ((hdr == TYPE_MEM) | is_prot);

  wire live      = clk_en_i & (st_q != D_BUSY);
  wire rx_done   = (st_q == D_RECV) & scl_fall & (bit_q == BYTE_BITS);
  wire take_data = live & ~start_ev & ~stop_ev & rx_done &
                   (kind_q == K_DATA) & ~prot_cmd_q;
  // Write cycle only when something is pending and the pin allows it
  wire commit    = live & stop_ev & ~wi_f & (|pvld_q);
  wire prot_go   = live & stop_ev & ~wi_f & prot_pend_q & ~prot_q;
  wire go_busy   = commit | prot_go;
  wire lower_lck = prot_q & ~ptr_q[ADDR_W-1];
  wire [DATA_W-1:0] rd_byte = mem_q[ptr_q];
  wire [PAGE_W-1:0] lo_next = ptr_q[PAGE_W-1:0] + 1'b1;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sy1_q      <= SY_RST;
      sy2_q      <= SY_RST;
      sy3_q      <= SY_RST;
      pin_q      <= SY_RST;
      pin_last_q <= SY_RST;
    end else if (clk_en_i) begin
      sy1_q      <= pin_raw;
      sy2_q      <= sy1_q;
      sy3_q      <= sy2_q;
      pin_q      <= pin_d;
      pin_last_q <= pin_q;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q        <= D_IDLE;
      kind_q      <= K_ADDR;
      bit_q       <= 4'h0;
      shift_q     <= 8'h00;
      ptr_q       <= 8'h00;
      pvld_q      <= 16'h0000;
      cnt_q       <= '0;
      rd_q        <= 1'b0;
      prot_cmd_q  <= 1'b0;
      prot_pend_q <= 1'b0;
      sda_oe_q    <= 1'b0;
      busy_q      <= 1'b0;
    end else if (clk_en_i) begin
      if (st_q == D_BUSY) begin
        // Deaf to the bus until the write cycle ends
        if (cnt_q == '0) begin
          st_q   <= D_IDLE;
          busy_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end else if (start_ev) begin
        // A fresh start drops any page data not closed by a stop
        st_q        <= D_RECV;
        kind_q      <= K_ADDR;
        bit_q       <= 4'h0;
        sda_oe_q    <= 1'b0;
        pvld_q      <= 16'h0000;
        prot_pend_q <= 1'b0;
      end else if (stop_ev) begin
        st_q        <= go_busy ? D_BUSY : D_IDLE;
        busy_q      <= go_busy;
        cnt_q       <= BUSY_LOAD;
        sda_oe_q    <= 1'b0;
        pvld_q      <= 16'h0000;
        prot_pend_q <= 1'b0;
      end else begin
        unique case (st_q)
          D_RECV: begin
            if (scl_rise) begin
              shift_q <= {shift_q[DATA_W-2:0], sda_f};
              bit_q   <= bit_q + 1'b1;
            end else if (rx_done) begin
              if (kind_q != K_ADDR || addr_hit) begin
                sda_oe_q <= 1'b1;
                st_q     <= D_ACK;
              end else begin
                st_q <= D_WAIT;
              end
              if (kind_q == K_ADDR) begin
                prot_cmd_q <= is_prot;
                rd_q       <= shift_q[0];
              end
              if (kind_q == K_WORD && !prot_cmd_q) begin
                ptr_q <= shift_q;
              end
              if (take_data) begin
                // Stay inside the page, wrapping onto earlier bytes
                pvld_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
                ptr_q <= {ptr_q[ADDR_W-1:PAGE_W], lo_next};
              end
              if (kind_q == K_DATA && prot_cmd_q) begin
                prot_pend_q <= 1'b1;
              end
            end
          end
          D_ACK: begin
            if (scl_fall) begin
              if (kind_q == K_ADDR && rd_q) begin
                // Byte at the counter; counter wraps over the array
                shift_q  <= rd_byte;
                ptr_q    <= ptr_q + 1'b1;
                sda_oe_q <= ~rd_byte[DATA_W-1];
                bit_q    <= 4'h1;
                st_q     <= D_SEND;
              end else begin
                sda_oe_q <= 1'b0;
                bit_q    <= 4'h0;
                kind_q   <= (kind_q == K_ADDR) ? K_WORD : K_DATA;
                st_q     <= D_RECV;
              end
            end
          end
          D_SEND: begin
            if (scl_fall) begin
              if (bit_q == BYTE_BITS) begin
                sda_oe_q <= 1'b0;
                st_q     <= D_MACK;
              end else begin
                sda_oe_q <= ~shift_q[DATA_W-2];
                shift_q  <= {shift_q[DATA_W-2:0], 1'b0};
                bit_q    <= bit_q + 1'b1;
              end
            end
          end
          D_MACK: begin
            // Master ack reloads via the ack state; nack waits for stop
            if (scl_rise) begin
              st_q <= sda_f ? D_WAIT : D_ACK;
            end
          end
          D_IDLE, D_WAIT, D_BUSY: begin
          end
        endcase
      end
    end
  end

  // Page buffer and array; array cells carry no reset
  always_ff @(posedge clock_i) begin
    if (take_data) begin
      page_q[ptr_q[PAGE_W-1:0]] <= shift_q;
    end
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commit && pvld_q[i] && !lower_lck) begin
        mem_q[{ptr_q[ADDR_W-1:PAGE_W], i[PAGE_W-1:0]}] <= page_q[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (prot_go) begin
      prot_q <= 1'b1;
    end
  end

  assign busy_o         = busy_q;
  assign protect_o      = prot_q;
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;

endmodule // tw_eeprom_dev

//--- core/tw_host_ctl.sv
/*
  Master end: byte-level two-wire bus master driven through a small
  register port (start, stop, write byte, read byte) plus the write
  inhibit pin. Assumes software sequences the commands and polls busy.
*/
`timescale 1ns/1ps
module tw_host_ctl (
  input  wire logic                      clock_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      clk_en_i,
  input  wire logic [tw_pkg::REG_AW-1:0] addr_i,
  input  wire logic [7:0]                wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [7:0]                rdata_o,
  tw_if.host                             bus
);
  import tw_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BITS} tw_host_state_t;

  tw_host_state_t  st_q;
  logic [QTR_W-1:0] div_q;
  logic [1:0]      ph_q;
  logic [3:0]      bit_q;
  logic [8:0]      tx_q;
  logic [8:0]      rx_q;
  logic [7:0]      txd_q;
  logic [7:0]      rxd_q;
  logic [7:0]      rdata_q;
  logic            ack_q;
  logic            frame_q;
  logic            wi_req_q;
  logic            wi_oe_q;
  logic            scl_q;
  logic            sda_oe_q;
  logic [2:0]      sy_q;
  logic            sda_f_q;

  localparam logic [QTR_W-1:0] QTR_LOAD = QTR_W'(QTR_CYCLES - 1);

  wire idle    = st_q == H_IDLE;
  wire cmd_wr  = wr_i & (addr_i == REG_CMD) & idle;
  wire tick    = ~idle & (div_q == '0);
  // Read frame sends ones then the ack bit; write frame releases the 9th
  wire [8:0] wr_frame = {txd_q, 1'b1};
  wire [8:0] rd_frame = {8'hFF, wdata_i[CMD_NACK]};
  wire [7:0] stat = {5'h00, frame_q, ack_q, ~idle};
  wire [7:0] rd_mux = (addr_i == REG_TXD)  ? txd_q :
                      (addr_i == REG_RXD)  ? rxd_q :
                      (addr_i == REG_STAT) ? stat :
                      (addr_i == REG_CTRL) ? {7'h00, wi_req_q} : 8'h00;
  wire sda_d = (sy_q[1] & sy_q[2]) | (sda_f_q & (sy_q[1] ^ sy_q[2]));

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sy_q    <= 3'h7;
      sda_f_q <= 1'b1;
      rdata_q <= 8'h00;
      txd_q   <= 8'h00;
      wi_req_q <= 1'b0;
    end else if (clk_en_i) begin
      sy_q    <= {sy_q[1:0], bus.sda};
      sda_f_q <= sda_d;
      if (rd_i) begin
        rdata_q <= rd_mux;
      end
      if (wr_i && addr_i == REG_TXD) begin
        txd_q <= wdata_i;
      end
      if (wr_i && addr_i == REG_CTRL) begin
        wi_req_q <= wdata_i[CTRL_WI];
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q     <= H_IDLE;
      div_q    <= '0;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      tx_q     <= 9'h1FF;
      rx_q     <= 9'h000;
      rxd_q    <= 8'h00;
      ack_q    <= 1'b0;
      frame_q  <= 1'b0;
      wi_oe_q  <= 1'b0;
      scl_q    <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (clk_en_i) begin
      if (idle) begin
        // Inhibit pin only moves between transfers
        if (!frame_q) begin
          wi_oe_q <= wi_req_q;
        end
        if (cmd_wr && wdata_i[CMD_START]) begin
          st_q     <= H_START;
          scl_q    <= 1'b0;
          sda_oe_q <= 1'b0;
        end else if (cmd_wr && wdata_i[CMD_STOP]) begin
          st_q     <= H_STOP;
          scl_q    <= 1'b0;
          sda_oe_q <= 1'b1;
        end else if (cmd_wr && (wdata_i[CMD_WRITE] || wdata_i[CMD_READ])) begin
          st_q     <= H_BITS;
          tx_q     <= wdata_i[CMD_WRITE] ? wr_frame : rd_frame;
          sda_oe_q <= wdata_i[CMD_WRITE] ? ~txd_q[7] : 1'b0;
          scl_q    <= 1'b0;
          bit_q    <= 4'h0;
        end
        div_q <= QTR_LOAD;
        ph_q  <= 2'h0;
      end else if (!tick) begin
        div_q <= div_q - 1'b1;
      end else begin
        div_q <= QTR_LOAD;
        ph_q  <= ph_q + 1'b1;
        unique case (ph_q)
          2'h0: scl_q <= 1'b1;
          2'h1: begin
            // Data moves with clock high only for start and stop
            if (st_q == H_START) begin
              sda_oe_q <= 1'b1;
            end else if (st_q == H_STOP) begin
              sda_oe_q <= 1'b0;
            end else begin
              rx_q <= {rx_q[7:0], sda_f_q};
            end
          end
          2'h2: begin
            if (st_q != H_STOP) begin
              scl_q <= 1'b0;
            end
          end
          2'h3: begin
            if (st_q == H_BITS && bit_q != FRAME_LAST) begin
              bit_q    <= bit_q + 1'b1;
              tx_q     <= {tx_q[7:0], 1'b1};
              sda_oe_q <= ~tx_q[7];
            end else begin
              st_q    <= H_IDLE;
              frame_q <= (st_q == H_START) ? 1'b1 :
                         (st_q == H_STOP) ? 1'b0 : frame_q;
              if (st_q == H_BITS) begin
                // First sample sits on top; bit 0 is the ack slot
                rxd_q <= rx_q[8:1];
                ack_q <= ~rx_q[0];
              end
            end
          end
        endcase
      end
    end
  end

  assign rdata_o         = rdata_q;
  assign bus.scl         = scl_q;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_oe_q;
  assign bus.wi_o        = 1'b1;
  assign bus.wi_oe       = wi_oe_q;

endmodule // tw_host_ctl

//--- bench/tw_link_assertions.sv
/*
  Concurrent checks on the two-wire link joining the master end and
  the EEPROM end, plus the device's busy and protect outputs.
  Assumes the testbench instantiates it beside the joining interface.
*/
`timescale 1ns/1ps
module tw_link_assertions #(
  parameter int unsigned BUSY_CYCLES = 200
) (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic dev_sda_oe,
  input  wire logic write_inhibit_pin,
  input  wire logic busy_o,
  input  wire logic protect_o
);
  logic        scl_q;
  logic        sda_q;
  logic        frame_q;
  logic        frame_d;
  logic [7:0]  since_stop_q;
  logic [7:0]  since_stop_d;
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  logic        start_ev;
  logic        stop_ev;

  assign start_ev     = scl & scl_q & sda_q & ~sda;
  assign stop_ev      = scl & scl_q & ~sda_q & sda;
  assign frame_d      = start_ev | (frame_q & ~stop_ev);
  // Saturates so a busy rise long after any stop still fails
  assign since_stop_d = stop_ev ? 8'h00
                      : since_stop_q + {7'h00, ~&since_stop_q};
  assign busy_cnt_d   = busy_o ? busy_cnt_q + 32'h1 : 32'h0;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_q        <= 1'b1;
      sda_q        <= 1'b1;
      frame_q      <= 1'b0;
      since_stop_q <= 8'hFF;
      busy_cnt_q   <= 32'h0;
    end else begin
      scl_q        <= scl;
      sda_q        <= sda;
      frame_q      <= frame_d;
      since_stop_q <= since_stop_d;
      busy_cnt_q   <= busy_cnt_d;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  a_busy_quiet: assert property (
    busy_o |-> !dev_sda_oe)
    else $error("device pulls data line while busy");
  a_busy_after_stop: assert property (
    $rose(busy_o) |-> since_stop_q <= 8'h10)
    else $error("busy rose without a recent stop");
  a_busy_holds: assert property (
    $rose(busy_o) |-> busy_o [*8])
    else $error("busy dropped right after rising");
  a_busy_length: assert property (
    $fell(busy_o) |-> busy_cnt_q >= BUSY_CYCLES - 1
                      && busy_cnt_q <= BUSY_CYCLES + 1)
    else $error("busy period length wrong");
  a_protect_sticky: assert property (
    protect_o |=> protect_o)
    else $error("protect flag cleared");
  a_protect_inhibit: assert property (
    $rose(protect_o) |-> !write_inhibit_pin)
    else $error("protect flag set with inhibit high");
  a_dev_edge_low: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_inhibit_steady: assert property (
    frame_q |-> $stable(write_inhibit_pin))
    else $error("inhibit changed inside a frame");
endmodule // tw_link_assertions

//--- bench/tb.sv
/*
  Top testbench: master end and EEPROM end joined by the interface,
  transfers driven through the master's register port.
  Assumes 50 MHz clock and a shortened busy period.
*/
`timescale 1ns/1ps
module tb;
  import tw_pkg::*;
  // Covers the poll's start condition yet keeps the run short
  localparam int unsigned BUSY = 1000;
  logic              clock_i   = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              clk_en    = 1'b1;
  logic [2:0]        sel       = 3'h5;
  logic [REG_AW-1:0] addr      = '0;
  logic [7:0]        wdata     = 8'h00;
  logic              wr        = 1'b0;
  logic              rd        = 1'b0;
  logic [7:0]        rdata;
  logic              busy;
  logic              prot;
  int                errors    = 0;
  int                tests_run = 0;
  int                cycles    = 0;

  tw_if bus_if ();
  tw_host_ctl tw_host_ctl_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .bus(bus_if));
  tw_eeprom_dev #(.BUSY_CYCLES(BUSY)) tw_eeprom_dev_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
    .select_bit0_i(sel[0]), .select_bit1_i(sel[1]),
    .select_bit2_i(sel[2]), .busy_o(busy), .protect_o(prot),
    .bus(bus_if));
  tw_link_assertions #(.BUSY_CYCLES(BUSY)) tw_link_assertions_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .scl(bus_if.scl),
    .sda(bus_if.sda), .dev_sda_oe(bus_if.dev_sda_oe),
    .write_inhibit_pin(bus_if.write_inhibit_pin), .busy_o(busy),
    .protect_o(prot));

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 120000) begin
      errors++;
      $display("[ERR] timeout expected done seen running");
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cmd(input logic [7:0] c);
    logic [7:0] s;
    reg_wr(REG_CMD, c);
    for (int n = 0; n < 4000; n++) begin
      reg_rd(REG_STAT, s);
      if (s[STAT_BUSY] === 1'b0) break;
    end
    if (s[STAT_BUSY] !== 1'b0) begin
      errors++;
      $display("[ERR] command done expected 0 seen %b", s[STAT_BUSY]);
    end
  endtask

  task automatic st();
    cmd(8'h01 << CMD_START);
  endtask

  task automatic sp();
    cmd(8'h01 << CMD_STOP);
  endtask

  task automatic op_wr(input logic [7:0] b, input logic ack);
    logic [7:0] s;
    reg_wr(REG_TXD, b);
    cmd(8'h01 << CMD_WRITE);
    reg_rd(REG_STAT, s);
    check("ack bit", {7'h00, ack}, {7'h00, s[STAT_ACK]});
  endtask

  task automatic op_rd(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    cmd((8'h01 << CMD_READ) | ({7'h00, nack} << CMD_NACK));
    reg_rd(REG_RXD, d);
    check("read byte", exp, d);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge clock_i);
    if (busy !== 1'b0) begin
      errors++;
      $display("[ERR] busy end expected 0 seen %b", busy);
    end
  endtask

  task automatic t_regs();
    logic [7:0] d;
    reg_rd(3'h7, d);
    check("unmapped", 8'h00, d);
    check("wi pin", 8'h00, {7'h00, bus_if.write_inhibit_pin});
    reg_wr(REG_CTRL, 8'h01);
    reg_rd(REG_CTRL, d);
    check("ctrl", 8'h01, d);
    check("wi pin", 8'h01, {7'h00, bus_if.write_inhibit_pin});
    reg_wr(REG_CTRL, 8'h00);
    // Clock enable low must freeze the register port
    clk_en <= 1'b0;
    reg_wr(REG_CTRL, 8'h01);
    clk_en <= 1'b1;
    reg_rd(REG_CTRL, d);
    check("ctrl frozen", 8'h00, d);
    check("protect", 8'h00, {7'h00, prot});
    $display("test regs done");
  endtask

  // Page write from the top of page 0 so the second byte wraps to 0x00
  task automatic t_page();
    st();
    op_wr(8'hAA, 1'b1);
    op_wr(8'h0F, 1'b1);
    op_wr(8'hC1, 1'b1);
    op_wr(8'hC2, 1'b1);
    op_wr(8'hC3, 1'b1);
    sp();
    check("busy", 8'h01, {7'h00, busy});
    $display("test page done");
  endtask

  task automatic t_poll();
    st();
    op_wr(8'hAA, 1'b0);
    sp();
    wait_idle();
    $display("test poll done");
  endtask

  task automatic t_inhibit();
    reg_wr(REG_CTRL, 8'h01);
    st();
    op_wr(8'hAA, 1'b1);
    op_wr(8'h01, 1'b1);
    op_wr(8'h55, 1'b1);
    sp();
    wait_idle();
    reg_wr(REG_CTRL, 8'h00);
    $display("test inhibit done");
  endtask

  task automatic t_protect();
    st();
    op_wr(8'h6A, 1'b1);
    op_wr(8'h00, 1'b1);
    op_wr(8'h00, 1'b1);
    sp();
    wait_idle();
    check("protect", 8'h01, {7'h00, prot});
    $display("test protect done");
  endtask

  task automatic t_refuse();
    st();
    op_wr(8'hA8, 1'b0);
    st();
    op_wr(8'h6B, 1'b0);
    sp();
    $display("test refuse done");
  endtask

  task automatic t_locked();
    st();
    op_wr(8'hAA, 1'b1);
    op_wr(8'h00, 1'b1);
    op_wr(8'h77, 1'b1);
    sp();
    wait_idle();
    $display("test locked done");
  endtask

  // 0x00 must still hold the wrapped byte, 0x01 the one before inhibit
  task automatic t_read();
    st();
    op_wr(8'hAA, 1'b1);
    op_wr(8'h00, 1'b1);
    st();
    op_wr(8'hAB, 1'b1);
    op_rd(1'b0, 8'hC2);
    op_rd(1'b1, 8'hC3);
    sp();
    $display("test read done");
  endtask

  initial begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_page();
    t_poll();
    t_inhibit();
    t_protect();
    t_refuse();
    t_locked();
    t_read();
    summarize();
  end
endmodule // tb
